//--- core/ueh_top.sv
// Unit error handler: fault capture, code posting, stop selection
`timescale 1ns/1ps
`default_nettype none
module ueh_top
  import ueh_pkg::*;
#(
  parameter int REFRESH_TMO_CYC = UEH_REFRESH_TMO_CYC
) (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        host_restart_i,
  input  wire logic        error_reset_i,
  input  wire logic        host_refresh_i,
  input  wire logic        host_fault_error_i,
  input  wire logic        pendant_slowdown_request_i,
  input  wire logic        param_download_i,
  input  wire logic        host_read_transfer_bad_i,
  input  wire logic        log_check_done_i,
  input  wire logic        log_check_bad_i,
  output logic [15:0]      error_code_o,
  output logic             error_active_o,
  output logic             emergency_stop_o,
  output logic             pendant_slowdown_request_o,
  output logic             log_reinit_o,
  output logic             params_pending_o
);

  // ----------------------------------------------------------------
  // Refresh supervision
  // ----------------------------------------------------------------
  ueh_watch_if wdi ();

  ueh_state_type st_q;
  ueh_state_type st_d;
  logic          armed_q;

  assign wdi.refresh = host_refresh_i;
  assign wdi.armed   = armed_q;

  ueh_watchdog #(
    .TMO_CYC (REFRESH_TMO_CYC)
  ) u_watchdog (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .wd     (wdi.dog)
  );

  // Arm only after the first refresh so a slow host start-up is not a fault
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      armed_q <= 1'b0;
    end else if (host_restart_i) begin
      armed_q <= 1'b0;
    end else if (host_refresh_i) begin
      armed_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Power-on error log check
  // ----------------------------------------------------------------
  wire log_bad_evt = (st_q == UEH_ST_CHECK) && log_check_done_i && log_check_bad_i;

  always_comb begin
    st_d = st_q;
    case (st_q)
      UEH_ST_CHECK: begin
        if (log_check_done_i) begin
          st_d = log_check_bad_i ? UEH_ST_INIT : UEH_ST_RUN;
        end
      end
      UEH_ST_INIT: st_d = UEH_ST_RUN;
      UEH_ST_RUN:  st_d = UEH_ST_RUN;
      default:     st_d = UEH_ST_CHECK;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= UEH_ST_CHECK;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Fault capture
  // ----------------------------------------------------------------
  logic [UEH_NFAULT-1:0] pend_q;
  logic [UEH_NFAULT-1:0] pend_d;
  logic [UEH_NFAULT-1:0] set_v;
  logic [UEH_NFAULT-1:0] clr_v;

  assign set_v[UEH_B_HOST]     = host_fault_error_i;
  // Expiry edge only: a standing expiry would overrule the restart that clears it
  logic bus_exp_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus_exp_q <= 1'b0;
    end else begin
      bus_exp_q <= wdi.expired;
    end
  end

  assign set_v[UEH_B_BUS]      = wdi.expired && !bus_exp_q;
  assign set_v[UEH_B_SLOWDOWN] = pendant_slowdown_request_i;
  assign set_v[UEH_B_SETUP]    = param_download_i;
  assign set_v[UEH_B_DATA]     = host_read_transfer_bad_i;
  assign set_v[UEH_B_LOG]      = log_bad_evt;

  assign clr_v[UEH_B_BUS]      = host_restart_i;
  assign clr_v[UEH_B_HOST]     = host_restart_i;
  assign clr_v[UEH_B_SLOWDOWN] = error_reset_i || host_restart_i;
  assign clr_v[UEH_B_SETUP]    = error_reset_i || host_restart_i;
  assign clr_v[UEH_B_DATA]     = error_reset_i || host_restart_i;
  assign clr_v[UEH_B_LOG]      = error_reset_i || host_restart_i;

  // Set wins over clear so a fault arriving with the reset is kept
  assign pend_d = set_v | (pend_q & ~clr_v);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pend_q <= '0;
    end else begin
      pend_q <= pend_d;
    end
  end

  // ----------------------------------------------------------------
  // Code selection
  // ----------------------------------------------------------------
  logic [15:0] code_d;
  logic [15:0] code_q;
  logic [15:0] new_code;
  wire         any_set = |set_v;
  wire         cur_live;

  // Newest event wins; simultaneous events by severity
  assign new_code = set_v[UEH_B_HOST]     ? UEH_CODE_HOST_ERR  :
                    set_v[UEH_B_BUS]      ? UEH_CODE_BUS_FATAL :
                    set_v[UEH_B_LOG]      ? UEH_CODE_LOG       :
                    set_v[UEH_B_DATA]     ? UEH_CODE_DATA      :
                    set_v[UEH_B_SETUP]    ? UEH_CODE_SETUP     :
                    UEH_CODE_SLOWDOWN;

  // Fallback when the shown fault clears but others remain
  logic [15:0] rem_code;
  assign rem_code = pend_d[UEH_B_HOST]     ? UEH_CODE_HOST_ERR  :
                    pend_d[UEH_B_BUS]      ? UEH_CODE_BUS_FATAL :
                    pend_d[UEH_B_LOG]      ? UEH_CODE_LOG       :
                    pend_d[UEH_B_DATA]     ? UEH_CODE_DATA      :
                    pend_d[UEH_B_SETUP]    ? UEH_CODE_SETUP     :
                    pend_d[UEH_B_SLOWDOWN] ? UEH_CODE_SLOWDOWN  :
                    UEH_CODE_NONE;

  assign cur_live = (code_q == UEH_CODE_HOST_ERR  && pend_d[UEH_B_HOST])     ||
                    (code_q == UEH_CODE_BUS_FATAL && pend_d[UEH_B_BUS])      ||
                    (code_q == UEH_CODE_LOG       && pend_d[UEH_B_LOG])      ||
                    (code_q == UEH_CODE_DATA      && pend_d[UEH_B_DATA])     ||
                    (code_q == UEH_CODE_SETUP     && pend_d[UEH_B_SETUP])    ||
                    (code_q == UEH_CODE_SLOWDOWN  && pend_d[UEH_B_SLOWDOWN]);

  assign code_d = any_set ? new_code : (cur_live ? code_q : rem_code);

  // ----------------------------------------------------------------
  // Stop selection and parameter staging
  // ----------------------------------------------------------------
  // emergency stop
  wire emerg_d = pend_d[UEH_B_HOST];
  wire decel_d = (|pend_d) && !emerg_d;

  logic params_q;

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      code_q           <= UEH_CODE_NONE;
      error_active_o   <= 1'b0;
      emergency_stop_o <= 1'b0;
      pendant_slowdown_request_o     <= 1'b0;
      log_reinit_o     <= 1'b0;
    end else begin
      code_q           <= code_d;
      error_active_o   <= |pend_d;
      emergency_stop_o <= emerg_d;
      pendant_slowdown_request_o     <= decel_d;
      log_reinit_o     <= (st_d == UEH_ST_INIT);
    end
  end

  // new parameters wait for power cycle
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      params_q <= 1'b0;
    end else if (param_download_i) begin
      params_q <= 1'b1;
    end
  end

  assign error_code_o     = code_q;
  assign params_pending_o = params_q;

endmodule : ueh_top
`default_nettype wire

//--- core/ueh_pkg.sv
// Package of constants and types for the unit error handler
package ueh_pkg;

  // ----------------------------------------------------------------
  // Error codes (4-digit hexadecimal)
  // ----------------------------------------------------------------
  localparam logic [15:0] UEH_CODE_NONE      = 16'h0000;
  localparam logic [15:0] UEH_CODE_BUS_FATAL = 16'h0007;
  localparam logic [15:0] UEH_CODE_HOST_ERR  = 16'h0009;
  localparam logic [15:0] UEH_CODE_SLOWDOWN  = 16'h000A;
  localparam logic [15:0] UEH_CODE_SETUP     = 16'h000B;
  localparam logic [15:0] UEH_CODE_DATA      = 16'h000C;
  localparam logic [15:0] UEH_CODE_LOG       = 16'h000D;

  // ----------------------------------------------------------------
  // Fault bit positions in the pending vector
  // ----------------------------------------------------------------
  localparam int UEH_NFAULT     = 6;
  localparam int UEH_B_HOST     = 0;
  localparam int UEH_B_BUS      = 1;
  localparam int UEH_B_SLOWDOWN = 2;
  localparam int UEH_B_SETUP    = 3;
  localparam int UEH_B_DATA     = 4;
  localparam int UEH_B_LOG      = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int UEH_CLK_HZ          = 40000000;
  localparam int UEH_REFRESH_TMO_US  = 1000;
  localparam int UEH_REFRESH_TMO_CYC = UEH_REFRESH_TMO_US * (UEH_CLK_HZ / 1000000);

  // Power-on log check states
  typedef enum logic [2:0] {
    UEH_ST_CHECK = 3'b001,
    UEH_ST_INIT  = 3'b010,
    UEH_ST_RUN   = 3'b100
  } ueh_state_type;

endpackage : ueh_pkg

//--- core/ueh_watch_if.sv
// Interface between the handler and its refresh watchdog
`timescale 1ns/1ps
`default_nettype none
interface ueh_watch_if;
  logic refresh;
  logic armed;
  logic expired;
  modport ctrl (output refresh, output armed, input expired);
  modport dog  (input refresh, input armed, output expired);
endinterface : ueh_watch_if
`default_nettype wire

//--- core/ueh_watchdog.sv
// Refresh watchdog counting cycles since the last host refresh
`timescale 1ns/1ps
`default_nettype none
module ueh_watchdog
  import ueh_pkg::*;
#(
  parameter int TMO_CYC = UEH_REFRESH_TMO_CYC
) (
  input  wire logic  mclk_i,
  input  wire logic  rstn_i,
  ueh_watch_if.dog   wd
);
  localparam int CW = $clog2(TMO_CYC + 1);
  localparam logic [CW-1:0] LIMIT = CW'(TMO_CYC);

  logic [CW-1:0] cnt_q;
  logic          exp_q;
  wire           at_limit = (cnt_q >= LIMIT);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (wd.refresh || !wd.armed) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else if (at_limit) begin
      exp_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign wd.expired = exp_q;
endmodule : ueh_watchdog
`default_nettype wire

//--- dv/ueh_top_properties.sv
// Port assertions for the unit error handler
`timescale 1ns/1ps
`default_nettype none
module ueh_top_checker
  import ueh_pkg::*;
(
  input wire logic        mclk_i,
  input wire logic        rstn_i,
  input wire logic        host_restart_i,
  input wire logic        error_reset_i,
  input wire logic        host_fault_error_i,
  input wire logic        pendant_slowdown_request_i,
  input wire logic        param_download_i,
  input wire logic        host_read_transfer_bad_i,
  input wire logic        log_check_bad_i,
  input wire logic [15:0] error_code_o,
  input wire logic        error_active_o,
  input wire logic        emergency_stop_o,
  input wire logic        pendant_slowdown_request_o,
  input wire logic        log_reinit_o,
  input wire logic        params_pending_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // Host and log sources quiet, so the newest code must win unless the bus watchdog expires in the same cycle
  wire logic calm = !host_fault_error_i && !log_check_bad_i && !emergency_stop_o;
  property p_host; host_fault_error_i |=> emergency_stop_o && error_code_o == 16'h0009; endproperty
  a_host: assert property (p_host) else $error("host fault not posted");
  property p_excl; emergency_stop_o |-> !pendant_slowdown_request_o; endproperty
  a_excl: assert property (p_excl) else $error("both stops active");
  property p_sticky; emergency_stop_o && !host_restart_i |=> emergency_stop_o; endproperty
  a_sticky: assert property (p_sticky) else $error("host fault cleared early");
  property p_bus; error_code_o == 16'h0007 && !host_restart_i |=> error_active_o; endproperty
  a_bus: assert property (p_bus) else $error("bus fault cleared early");
  property p_slow;
    pendant_slowdown_request_i && calm && !param_download_i && !host_read_transfer_bad_i
      |=> error_code_o == UEH_CODE_SLOWDOWN && pendant_slowdown_request_o;
  endproperty
  a_slow: assert property (p_slow) else $error("slowdown not posted");
  property p_data; host_read_transfer_bad_i && calm |=> error_code_o == UEH_CODE_DATA; endproperty
  a_data: assert property (p_data) else $error("data fault not posted");
  property p_setup; param_download_i |=> params_pending_o && error_active_o; endproperty
  a_setup: assert property (p_setup) else $error("setup fault not posted");
  property p_keep; params_pending_o |=> $stable(params_pending_o); endproperty
  a_keep: assert property (p_keep) else $error("pending params dropped");
  property p_hold; error_active_o && !error_reset_i && !host_restart_i |=> error_active_o; endproperty
  a_hold: assert property (p_hold) else $error("code dropped early");
  property p_reinit; log_reinit_o |=> !log_reinit_o [*3]; endproperty
  a_reinit: assert property (p_reinit) else $error("log reinit repeated");
endmodule : ueh_top_checker
bind ueh_top ueh_top_checker u_chk (
  .mclk_i(mclk_i), .rstn_i(rstn_i), .host_restart_i(host_restart_i),
  .error_reset_i(error_reset_i), .host_fault_error_i(host_fault_error_i),
  .pendant_slowdown_request_i(pendant_slowdown_request_i), .param_download_i(param_download_i),
  .host_read_transfer_bad_i(host_read_transfer_bad_i), .log_check_bad_i(log_check_bad_i),
  .error_code_o(error_code_o), .error_active_o(error_active_o),
  .emergency_stop_o(emergency_stop_o), .pendant_slowdown_request_o(pendant_slowdown_request_o),
  .log_reinit_o(log_reinit_o), .params_pending_o(params_pending_o)
);
`default_nettype wire

//--- dv/ueh_host_model.sv
// Host controller model: periodic refresh, fault report and restart
`timescale 1ns/1ps
`default_nettype none
module ueh_host_model #(
  parameter int PERIOD = 8
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  input  wire logic run_i,
  input  wire logic fault_i,
  input  wire logic restart_i,
  output logic      host_refresh_o,
  output logic      host_fault_error_o,
  output logic      host_restart_o
);
  int cnt_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_q <= 0;
      host_refresh_o <= 1'b0;
    end else begin
      cnt_q <= (!run_i || cnt_q == PERIOD - 1) ? 0 : cnt_q + 1;
      host_refresh_o <= run_i && cnt_q == PERIOD - 1;
    end
  end
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      host_fault_error_o <= 1'b0;
      host_restart_o <= 1'b0;
    end else begin
      host_fault_error_o <= fault_i;
      host_restart_o <= restart_i;
    end
  end
endmodule : ueh_host_model
`default_nettype wire

//--- dv/testbench.sv
// Self-checking bench for the unit error handler
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ueh_pkg::*;
;
  logic        mclk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  ev = 8'h00;
  logic        run = 1'b0;
  logic        rf, hf, hr, act, emg, dec, rei, pp;
  logic [15:0] code;
  int          failures = 0;
  int          samples_checked = 0;
  int          reinits = 0;
  ueh_host_model #(.PERIOD(8)) host (.mclk_i(mclk_i), .rstn_i(rstn_i), .run_i(run),
    .fault_i(ev[6]), .restart_i(ev[7]), .host_refresh_o(rf), .host_fault_error_o(hf),
    .host_restart_o(hr));
  ueh_top #(.REFRESH_TMO_CYC(20)) dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .host_restart_i(hr),
    .error_reset_i(ev[0]), .host_refresh_i(rf), .host_fault_error_i(hf),
    .pendant_slowdown_request_i(ev[1]), .param_download_i(ev[2]),
    .host_read_transfer_bad_i(ev[3]), .log_check_done_i(ev[4]), .log_check_bad_i(ev[5]),
    .error_code_o(code), .error_active_o(act), .emergency_stop_o(emg), .pendant_slowdown_request_o(dec),
    .log_reinit_o(rei), .params_pending_o(pp));
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    if (rei === 1'b1) reinits++;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Code plus active, emergency and decel flags
  task automatic ck(input logic [15:0] e, input logic [2:0] f);
    chk(code, e);
    chk({13'h0000, act, emg, dec}, {13'h0000, f});
  endtask : ck
  // One-cycle event, then settle past the host model register stage
  task automatic pu(input logic [7:0] m);
    @(posedge mclk_i);
    ev <= m;
    @(posedge mclk_i);
    ev <= 8'h00;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : pu
  task automatic t_log();
    pu(8'h30);
    ck(UEH_CODE_LOG, 3'b101);
    chk(16'(reinits), 16'h0001);
    pu(8'h01);
    ck(UEH_CODE_NONE, 3'b000);
    $display("log test done");
  endtask : t_log
  task automatic t_codes();
    pu(8'h02);
    ck(UEH_CODE_SLOWDOWN, 3'b101);
    pu(8'h08);
    ck(UEH_CODE_DATA, 3'b101);
    pu(8'h01);
    ck(UEH_CODE_NONE, 3'b000);
    pu(8'h04);
    ck(UEH_CODE_SETUP, 3'b101);
    pu(8'h01);
    ck(UEH_CODE_NONE, 3'b000);
    chk({15'h0000, pp}, 16'h0001);
    $display("code test done");
  endtask : t_codes
  task automatic t_bus();
    int n;
    @(posedge mclk_i);
    run <= 1'b1;
    repeat (60) @(posedge mclk_i);
    run <= 1'b0;
    #1;
    ck(UEH_CODE_NONE, 3'b000);
    n = 0;
    while (code !== UEH_CODE_BUS_FATAL && n < 40) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= 40) begin
      failures++;
      $display("[ERR] %0t watchdog wait ran out", $time);
      print_verdict();
    end
    ck(UEH_CODE_BUS_FATAL, 3'b101);
    pu(8'h01);
    ck(UEH_CODE_BUS_FATAL, 3'b101);
    pu(8'h80);
    ck(UEH_CODE_NONE, 3'b000);
    $display("bus test done");
  endtask : t_bus
  task automatic t_host();
    pu(8'h40);
    ck(UEH_CODE_HOST_ERR, 3'b110);
    pu(8'h03);
    ck(UEH_CODE_SLOWDOWN, 3'b110);
    pu(8'h01);
    ck(UEH_CODE_HOST_ERR, 3'b110);
    pu(8'h80);
    ck(UEH_CODE_NONE, 3'b000);
    chk({15'h0000, pp}, 16'h0001);
    $display("host test done");
  endtask : t_host
  // Power cycle drops staged parameters; a sound log raises nothing
  task automatic t_power();
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    ck(UEH_CODE_NONE, 3'b000);
    chk({15'h0000, pp}, 16'h0000);
    pu(8'h10);
    ck(UEH_CODE_NONE, 3'b000);
    chk(16'(reinits), 16'h0001);
    $display("power test done");
  endtask : t_power
  initial begin
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    ck(UEH_CODE_NONE, 3'b000);
    t_log();
    t_codes();
    t_bus();
    t_host();
    t_power();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
